// ---- logic/mbd_dispatch.sv ----
// Station address selection and function-code dispatch for the slave.
`timescale 1ns/10ps
//
// Summary of operation
// (R1) Switch address 0..31 from five switches weighted 1,2,4,8,16.
// (R2) Addresses 32..255 come only from a stored value written by config.
// (R3) Output bit space serves codes 1, 5 and 15; 5 and 15 write.
// (R4) Input bit space is read only, reached only by code 2.
// (R5) Input register space is read only, reached by code 3.
// (R6) Holding register space serves codes 4, 6, 16; 6 and 16 write.
// (R7) Every register word passed on is sixteen bits.
// (R8) Only frames in the selected framing, RTU or ASCII, are served.
// (R9) Restore switch on at start clears settings; LED lit until switched off.
// (R10) Communication LED lights when a correct packet is answered.
// (R11) Frames for another station are ignored and never answered.
module mbd_dispatch #(
  parameter int COMM_LED_CYCLES = mbd_pkg::COMM_LED_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Switch pins, index 0 weighs one, index 5 is the restore switch
  input wire logic [5:0] switch_pins_in,
  // Configuration writes from the bus or the configuration port
  input wire logic cfg_addr_wr_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic cfg_mode_wr_in,
  input wire logic cfg_mode_in,
  // Parsed request from the frame decoder
  input wire logic req_valid_in,
  input wire logic req_ascii_in,
  input wire logic [7:0] req_station_in,
  input wire logic [7:0] req_func_in,
  input wire logic [15:0] req_offset_in,
  input wire logic [15:0] req_count_in,
  input wire logic [15:0] req_data_in,
  // Dispatched access
  output logic disp_valid_out,
  output mbd_pkg::mbd_space_t disp_space_out,
  output logic disp_write_out,
  output logic [15:0] disp_offset_out,
  output logic [15:0] disp_count_out,
  output logic [15:0] disp_data_out,
  // Exception answer
  output logic exc_valid_out,
  output logic [7:0] exc_code_out,
  // Status
  output logic [7:0] station_addr_out,
  output logic ascii_mode_out,
  output logic restore_out,
  output logic comm_led_out
);

  logic [5:0] switches;
  logic [7:0] stored_addr;
  logic [7:0] next_station;
  logic accept;
  logic known;
  logic is_write;
  logic [31:0] led_count;
  logic [1:0] boot_wait;
  mbd_pkg::mbd_state_t state;
  mbd_pkg::mbd_space_t next_space;

  mbd_sync #(
    .WIDTH(mbd_pkg::SWITCH_COUNT)
  ) u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .pin_in(switch_pins_in),
    .level_out(switches)
  );

  // The stored address wins only when it lies above the switch range.
  always_comb
  begin
    if (stored_addr >= mbd_pkg::STORED_ADDR_MIN)
      next_station = stored_addr; // R2
    else
      next_station = {3'h0, switches[mbd_pkg::ADDR_SWITCH_BITS-1:0]}; // R1
  end

  always_comb
  begin
    known = 1'b1;
    is_write = 1'b0;
    next_space = mbd_pkg::SPACE_OUT_BITS;
    case (req_func_in)
      mbd_pkg::FC_READ_OUT_BITS: next_space = mbd_pkg::SPACE_OUT_BITS; // R3
      mbd_pkg::FC_WRITE_OUT_BIT,
      mbd_pkg::FC_WRITE_OUT_BITS:
      begin
        next_space = mbd_pkg::SPACE_OUT_BITS; // R3
        is_write = 1'b1;
      end
      mbd_pkg::FC_READ_IN_BITS: next_space = mbd_pkg::SPACE_IN_BITS; // R4
      mbd_pkg::FC_READ_IN_REGS: next_space = mbd_pkg::SPACE_IN_REGS; // R5
      mbd_pkg::FC_READ_HOLD_REGS: next_space = mbd_pkg::SPACE_HOLD_REGS; // R6
      mbd_pkg::FC_WRITE_HOLD_REG,
      mbd_pkg::FC_WRITE_HOLD_REGS:
      begin
        next_space = mbd_pkg::SPACE_HOLD_REGS; // R6
        is_write = 1'b1;
      end
      default: known = 1'b0;
    endcase
  end

  // A frame is served only in run state, in the selected framing and for us.
  assign accept = req_valid_in && (state == mbd_pkg::ST_RUN)
    && (req_ascii_in == ascii_mode_out) // R8
    && (req_station_in == station_addr_out); // R11

  // The restore switch is sampled once, only after the synchroniser has
  // settled; sampling earlier would always see the reset value of zero.
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      state <= mbd_pkg::ST_BOOT;
    else
    begin
      case (state)
        mbd_pkg::ST_BOOT:
          if (boot_wait != 2'h2)
            state <= mbd_pkg::ST_BOOT;
          else if (switches[mbd_pkg::RESTORE_SWITCH_POS])
            state <= mbd_pkg::ST_RESTORE; // R9
          else
            state <= mbd_pkg::ST_RUN;
        mbd_pkg::ST_RESTORE:
          if (!switches[mbd_pkg::RESTORE_SWITCH_POS])
            state <= mbd_pkg::ST_RUN; // R9
        default: state <= mbd_pkg::ST_RUN;
      endcase
    end
  end

  // The synchroniser needs two edges, so the boot state waits them out.
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      boot_wait <= 2'h0;
    else if (boot_wait != 2'h3)
      boot_wait <= boot_wait + 2'h1;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      restore_out <= 1'b0;
    else
      restore_out <= (state == mbd_pkg::ST_BOOT) && (boot_wait == 2'h2)
        && switches[mbd_pkg::RESTORE_SWITCH_POS]; // R9
  end

  // Settings that the restore clears back to factory values.
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in || restore_out)
    begin
      stored_addr <= mbd_pkg::STORED_ADDR_RESET; // R9
      ascii_mode_out <= mbd_pkg::FRAMING_RTU;
    end
    else
    begin
      if (cfg_addr_wr_in)
        stored_addr <= cfg_addr_in; // R2
      if (cfg_mode_wr_in)
        ascii_mode_out <= cfg_mode_in; // R8
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      station_addr_out <= 8'h00;
    else
      station_addr_out <= next_station;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      disp_valid_out <= 1'b0;
      disp_space_out <= mbd_pkg::SPACE_OUT_BITS;
      disp_write_out <= 1'b0;
      disp_offset_out <= 16'h0000;
      disp_count_out <= 16'h0000;
      disp_data_out <= 16'h0000;
      exc_valid_out <= 1'b0;
      exc_code_out <= 8'h00;
    end
    else
    begin
      disp_valid_out <= accept && known;
      exc_valid_out <= accept && !known;
      exc_code_out <= mbd_pkg::EXC_ILLEGAL_FUNCTION;
      if (accept && known)
      begin
        disp_space_out <= next_space;
        disp_write_out <= is_write;
        disp_offset_out <= req_offset_in;
        disp_count_out <= req_count_in;
        disp_data_out <= req_data_in; // R7
      end
    end
  end

  // A long stretch keeps a single short reply visible to the eye.
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      led_count <= 32'h0000_0000;
    else if (accept && known)
      led_count <= 32'(COMM_LED_CYCLES); // R10
    else if (led_count != 32'h0000_0000)
      led_count <= led_count - 32'h0000_0001;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      comm_led_out <= 1'b0;
    else
      comm_led_out <= (led_count != 32'h0000_0000)
        || (state == mbd_pkg::ST_RESTORE); // R10
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  switch_addr_a: assert property ( // R1
    (stored_addr < mbd_pkg::STORED_ADDR_MIN) |=>
      station_addr_out == {3'h0, $past(switches[4:0])})
    else $error("switch address not used");
  stored_addr_a: assert property ( // R2
    (stored_addr >= mbd_pkg::STORED_ADDR_MIN) |=>
      station_addr_out == $past(stored_addr))
    else $error("stored address not used");
  out_bits_a: assert property ( // R3
    accept && (req_func_in == mbd_pkg::FC_WRITE_OUT_BITS) |=>
      disp_valid_out && disp_write_out
      && disp_space_out == mbd_pkg::SPACE_OUT_BITS)
    else $error("code 15 misrouted");
  in_bits_a: assert property ( // R4
    disp_valid_out && disp_space_out == mbd_pkg::SPACE_IN_BITS |->
      !disp_write_out && $past(req_func_in) == mbd_pkg::FC_READ_IN_BITS)
    else $error("input bits reached wrongly");
  in_regs_a: assert property ( // R5
    accept && (req_func_in == mbd_pkg::FC_READ_IN_REGS) |=>
      disp_valid_out && !disp_write_out
      && disp_space_out == mbd_pkg::SPACE_IN_REGS)
    else $error("code 3 misrouted");
  hold_regs_a: assert property ( // R6
    accept && (req_func_in == mbd_pkg::FC_WRITE_HOLD_REG) |=>
      disp_write_out && disp_space_out == mbd_pkg::SPACE_HOLD_REGS
      && disp_data_out == $past(req_data_in))
    else $error("code 6 misrouted");
  framing_a: assert property ( // R8
    req_valid_in && (req_ascii_in != ascii_mode_out) |=>
      !disp_valid_out && !exc_valid_out)
    else $error("wrong framing answered");
  restore_clear_a: assert property ( // R9
    restore_out |=> stored_addr == mbd_pkg::STORED_ADDR_RESET
      && ascii_mode_out == mbd_pkg::FRAMING_RTU ##1 comm_led_out)
    else $error("restore did not clear settings");
  comm_led_a: assert property ( // R10
    disp_valid_out |=> comm_led_out [*2])
    else $error("indicator not lit on reply");
  foreign_addr_a: assert property ( // R11
    req_valid_in && (req_station_in != station_addr_out) |=>
      !disp_valid_out && !exc_valid_out)
    else $error("foreign frame answered");

  write_seen_c: cover property (disp_valid_out && disp_write_out);
  exc_seen_c: cover property (exc_valid_out);
  high_addr_c: cover property (accept && station_addr_out > 8'h1F);
  restore_seen_c: cover property (restore_out);

endmodule

// ---- logic/mbd_pkg.sv ----
// Shared constants and types for the station-address and dispatch block.
package mbd_pkg;

  // Station address ranges.
  localparam logic [7:0] SWITCH_ADDR_MAX = 8'h1F;
  localparam logic [7:0] STORED_ADDR_MIN = 8'h20;
  localparam logic [7:0] STORED_ADDR_RESET = 8'h00;
  localparam int SWITCH_COUNT = 6;
  localparam int ADDR_SWITCH_BITS = 5;
  localparam int RESTORE_SWITCH_POS = 5;

  // Function codes served by the dispatcher, and its exception code.
  localparam logic [7:0] FC_READ_OUT_BITS = 8'h01;
  localparam logic [7:0] FC_READ_IN_BITS = 8'h02;
  localparam logic [7:0] FC_READ_IN_REGS = 8'h03;
  localparam logic [7:0] FC_READ_HOLD_REGS = 8'h04;
  localparam logic [7:0] FC_WRITE_OUT_BIT = 8'h05;
  localparam logic [7:0] FC_WRITE_HOLD_REG = 8'h06;
  localparam logic [7:0] FC_WRITE_OUT_BITS = 8'h0F;
  localparam logic [7:0] FC_WRITE_HOLD_REGS = 8'h10;
  localparam logic [7:0] EXC_ILLEGAL_FUNCTION = 8'h01;

  // First reference number of each data space.
  localparam int REF_BASE_OUT_BITS = 1;
  localparam int REF_BASE_IN_BITS = 10001;
  localparam int REF_BASE_IN_REGS = 30001;
  localparam int REF_BASE_HOLD_REGS = 40001;

  // Every register word is sixteen bits wide.
  localparam int WORD_W = 16;

  // Framing modes.
  localparam logic FRAMING_RTU = 1'b0;
  localparam logic FRAMING_ASCII = 1'b1;

  // Communication indicator stretch.
  localparam int CLK_HZ = 40000000;
  localparam int COMM_LED_MS = 50;
  localparam int COMM_LED_CYCLES = COMM_LED_MS * (CLK_HZ / 1000);

  typedef enum logic [1:0] {
    SPACE_OUT_BITS = 2'b00,
    SPACE_IN_BITS = 2'b01,
    SPACE_IN_REGS = 2'b10,
    SPACE_HOLD_REGS = 2'b11
  } mbd_space_t;

  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_RESTORE = 2'b01,
    ST_RUN = 2'b10
  } mbd_state_t;

endpackage

// ---- logic/mbd_sync.sv ----
// Two-stage synchroniser for a group of pin inputs.
`timescale 1ns/10ps
module mbd_sync #(
  parameter int WIDTH = 6
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Pins and synchronised levels
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] stage1;

  // The first stage feeds only the second.
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      stage1 <= '0;
      level_out <= '0;
    end
    else
    begin
      stage1 <= pin_in;
      level_out <= stage1;
    end
  end

endmodule

// ---- test/mbd_master_model.sv ----
// Bus master model that hands parsed requests and config writes to the block.
`timescale 1ns/10ps
module mbd_master_model (
  // Clock
  input wire logic clk_sys_in,
  // Parsed request
  output logic req_valid_out,
  output logic req_ascii_out,
  output logic [7:0] req_station_out,
  output logic [7:0] req_func_out,
  output logic [15:0] req_offset_out,
  output logic [15:0] req_count_out,
  output logic [15:0] req_data_out,
  // Configuration writes
  output logic cfg_addr_wr_out,
  output logic [7:0] cfg_addr_out,
  output logic cfg_mode_wr_out,
  output logic cfg_mode_out
);
  initial
  begin
    {req_valid_out, req_ascii_out, req_station_out, req_func_out} = '0;
    {req_offset_out, req_count_out, req_data_out} = '0;
    {cfg_addr_wr_out, cfg_addr_out, cfg_mode_wr_out, cfg_mode_out} = '0;
  end

  // One request frame, held for exactly one taking edge.
  task automatic send(input logic [7:0] st, input logic [7:0] fc,
                      input logic asc, input logic [15:0] off,
                      input logic [15:0] cnt, input logic [15:0] dat);
    @(negedge clk_sys_in);
    req_valid_out = 1'b1;
    req_ascii_out = asc;
    req_station_out = st;
    req_func_out = fc;
    {req_offset_out, req_count_out, req_data_out} = {off, cnt, dat};
    @(negedge clk_sys_in);
    req_valid_out = 1'b0;
    // Released fields are inverted so a stale copy can never look live.
    req_ascii_out = ~asc;
    req_station_out = ~st;
    req_func_out = ~fc;
    {req_offset_out, req_count_out, req_data_out} = ~{off, cnt, dat};
  endtask

  task automatic set_addr(input logic [7:0] v);
    @(negedge clk_sys_in);
    cfg_addr_wr_out = 1'b1;
    cfg_addr_out = v;
    @(negedge clk_sys_in);
    cfg_addr_wr_out = 1'b0;
    cfg_addr_out = ~v;
  endtask

  task automatic set_mode(input logic m);
    @(negedge clk_sys_in);
    cfg_mode_wr_out = 1'b1;
    cfg_mode_out = m;
    @(negedge clk_sys_in);
    cfg_mode_wr_out = 1'b0;
    cfg_mode_out = ~m;
  endtask
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for station address selection and dispatch.
`timescale 1ns/10ps
module tb_top;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic [5:0] switch_pins_in = 6'h00;
  logic req_valid, req_ascii, cfg_addr_wr, cfg_mode_wr, cfg_mode;
  logic [7:0] req_station, req_func, cfg_addr, exc_code, station, sw, addr;
  logic [15:0] req_offset, req_count, req_data;
  logic [15:0] disp_offset, disp_count, disp_data;
  logic disp_valid, disp_write, exc_valid, ascii_mode, comm_led, restore;
  mbd_pkg::mbd_space_t disp_space;
  int miscompares = 0;
  int check_count = 0;
  int r;
  integer seed = 32'ha035;
  logic [7:0] codes [10] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
                             8'h0F, 8'h10, 8'h07, 8'h2B};

  always #12.5 clk_sys_in = ~clk_sys_in;

  mbd_dispatch #(.COMM_LED_CYCLES(8)) u_dut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .switch_pins_in(switch_pins_in),
    .cfg_addr_wr_in(cfg_addr_wr), .cfg_addr_in(cfg_addr),
    .cfg_mode_wr_in(cfg_mode_wr), .cfg_mode_in(cfg_mode),
    .req_valid_in(req_valid), .req_ascii_in(req_ascii),
    .req_station_in(req_station), .req_func_in(req_func),
    .req_offset_in(req_offset), .req_count_in(req_count),
    .req_data_in(req_data),
    .disp_valid_out(disp_valid), .disp_space_out(disp_space),
    .disp_write_out(disp_write), .disp_offset_out(disp_offset),
    .disp_count_out(disp_count), .disp_data_out(disp_data),
    .exc_valid_out(exc_valid), .exc_code_out(exc_code),
    .station_addr_out(station), .ascii_mode_out(ascii_mode),
    .restore_out(restore), .comm_led_out(comm_led));

  mbd_master_model u_master (
    .clk_sys_in(clk_sys_in), .req_valid_out(req_valid),
    .req_ascii_out(req_ascii), .req_station_out(req_station),
    .req_func_out(req_func), .req_offset_out(req_offset),
    .req_count_out(req_count), .req_data_out(req_data),
    .cfg_addr_wr_out(cfg_addr_wr), .cfg_addr_out(cfg_addr),
    .cfg_mode_wr_out(cfg_mode_wr), .cfg_mode_out(cfg_mode));

  function automatic int exp_space(input logic [7:0] fc);
    case (fc)
      8'h01, 8'h05, 8'h0F: return 0;
      8'h02: return 1;
      8'h03: return 2;
      8'h04, 8'h06, 8'h10: return 3;
      default: return -1;
    endcase
  endfunction

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Sends one frame and checks the answer in the cycle after the taking edge.
  task automatic req(input logic [7:0] st, input logic [7:0] fc,
                     input logic asc, input logic take);
    logic [15:0] off, cnt, dat;
    logic wr;
    int sp;
    {off, cnt} = {$random(seed)};
    dat = 16'($random(seed));
    sp = exp_space(fc);
    wr = fc inside {8'h05, 8'h06, 8'h0F, 8'h10};
    u_master.send(st, fc, asc, off, cnt, dat);
    chk("disp_valid", {15'h0000, take && sp >= 0}, {15'h0000, disp_valid});
    chk("exc_valid", {15'h0000, take && sp < 0}, {15'h0000, exc_valid});
    if (take && sp >= 0)
    begin
      chk("space", sp[15:0], {14'h0000, disp_space});
      chk("write", {15'h0000, wr}, {15'h0000, disp_write});
      chk("offset", off, disp_offset);
      chk("count", cnt, disp_count);
      chk("data", dat, disp_data);
    end
    if (take && sp < 0)
      chk("exc_code", {8'h00, mbd_pkg::EXC_ILLEGAL_FUNCTION},
          {8'h00, exc_code});
  endtask

  initial
  begin
    repeat (10) @(negedge clk_sys_in);
    rst_in = 1'b0;
    for (int a = 0; a < 32; a++)
    begin
      switch_pins_in = {1'b0, a[4:0]};
      repeat (5) @(negedge clk_sys_in);
      chk("station", {11'h000, a[4:0]}, {8'h00, station});
    end
    r = $random(seed);
    sw = {3'h0, r[4:0]};
    switch_pins_in = {1'b0, sw[4:0]};
    repeat (5) @(negedge clk_sys_in);
    // The indicator is checked from idle, before other traffic retriggers it.
    req(sw, 8'h02, 1'b0, 1'b1);
    chk("led", 16'h0000, {15'h0000, comm_led});
    @(negedge clk_sys_in);
    chk("led", 16'h0001, {15'h0000, comm_led});
    repeat (6) @(negedge clk_sys_in);
    chk("led", 16'h0001, {15'h0000, comm_led});
    repeat (3) @(negedge clk_sys_in);
    chk("led", 16'h0000, {15'h0000, comm_led});
    foreach (codes[i]) req(sw, codes[i], 1'b0, 1'b1);
    req(sw ^ 8'h01, 8'h03, 1'b0, 1'b0);
    req(sw ^ 8'h80, 8'h01, 1'b0, 1'b0);
    req(sw, 8'h03, 1'b1, 1'b0);
    u_master.set_mode(1'b1);
    repeat (2) @(negedge clk_sys_in);
    chk("ascii_mode", 16'h0001, {15'h0000, ascii_mode});
    req(sw, 8'h04, 1'b1, 1'b1);
    req(sw, 8'h04, 1'b0, 1'b0);
    for (int k = 0; k < 3; k++)
    begin
      r = $random(seed);
      addr = (k == 0) ? 8'h20 : (k == 1) ? 8'hFF : {1'b1, r[6:0]};
      u_master.set_addr(addr);
      repeat (2) @(negedge clk_sys_in);
      chk("station", {8'h00, addr}, {8'h00, station});
      req(addr, 8'h06, 1'b1, 1'b1);
      req(sw, 8'h10, 1'b1, 1'b0);
    end
    u_master.set_addr(8'h1F);
    repeat (2) @(negedge clk_sys_in);
    chk("station", {8'h00, sw}, {8'h00, station});
    // A second reset with the restore switch on brings back factory settings.
    rst_in = 1'b1;
    switch_pins_in = {1'b1, sw[4:0]};
    repeat (10) @(negedge clk_sys_in);
    rst_in = 1'b0;
    repeat (3) @(negedge clk_sys_in);
    chk("restore", 16'h0001, {15'h0000, restore});
    @(negedge clk_sys_in);
    chk("restore", 16'h0000, {15'h0000, restore});
    repeat (4) @(negedge clk_sys_in);
    chk("led", 16'h0001, {15'h0000, comm_led});
    switch_pins_in = {1'b0, sw[4:0]};
    repeat (4) @(negedge clk_sys_in);
    chk("led", 16'h0000, {15'h0000, comm_led});
    chk("ascii_mode", 16'h0000, {15'h0000, ascii_mode});
    chk("station", {8'h00, sw}, {8'h00, station});
    req(sw, 8'h01, 1'b0, 1'b1);
    results();
  end

  // The whole sequence needs well under a thousand cycles.
  initial
  begin
    repeat (5000) @(posedge clk_sys_in);
    miscompares++;
    results();
  end
endmodule
